// [hdl/rxpop_pkg.sv]
// Constants and types shared by the receive payload output port.
// Assumes nothing of its surroundings.
package rxpop_pkg;

   // ----------------------------------------
   // Widths and buffer entry layout
   // ----------------------------------------
   localparam int NIB_W        = 4;
   localparam int ENTRY_W      = 3;
   localparam int ENT_BIT      = 0;
   localparam int ENT_FIRST    = 1;
   localparam int ENT_OH       = 2;
   localparam int BUF_DEPTH    = 2;
   // Payload nibble clock pulses per inbound frame, reached when frames flow at line rate
   localparam int FRAME_NIBBLES = 1176;

   // ----------------------------------------
   // Modes and nibble clock phases
   // ----------------------------------------
   typedef enum logic {
      MODE_SERIAL = 1'b0,
      MODE_NIBBLE = 1'b1
   } rxpop_mode_t;

   // One line period high, three low: the 25 percent nibble clock
   typedef enum logic [1:0] {
      PH_HIGH = 2'b00,
      PH_LOW1 = 2'b01,
      PH_LOW2 = 2'b10,
      PH_LOW3 = 2'b11
   } rxpop_phase_t;

endpackage

// [hdl/rxpop_fifo.sv]
// Small valid/ready buffer with flip-flop storage.
// Assumes both sides run on clk; ready is registered.
`timescale 1ns/10ps
module rxpop_fifo #(
   parameter int WIDTH = 3,
   parameter int DEPTH = 2
) (
   // Clock and reset
   input  wire logic             clk,
   input  wire logic             rst_n,
   // Fill side
   input  wire logic             in_valid,
   input  wire logic [WIDTH-1:0] in_data,
   output logic                  in_ready,
   // Drain side
   output logic                  out_valid,
   output logic      [WIDTH-1:0] out_data,
   input  wire logic             out_ready
);
   localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam int CW = $clog2(DEPTH + 1);
   localparam logic [CW-1:0] CNT_FULL = CW'(DEPTH);
   localparam logic [PW-1:0] PTR_LAST = PW'(DEPTH - 1);

   generate
      if (DEPTH < 2 || WIDTH < 1) begin : g_bad
         $error("rxpop_fifo needs DEPTH of at least 2 and WIDTH of at least 1");
      end
   endgenerate

   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [WIDTH-1:0] mem_d [DEPTH];
   logic [PW-1:0]    wr_q, wr_d, rd_q, rd_d;
   logic [CW-1:0]    cnt_q, cnt_d;
   logic             rdy_q, rdy_d;
   logic             push, pop;

   assign push      = in_valid && rdy_q;
   assign pop       = out_ready && (cnt_q != '0);
   assign in_ready  = rdy_q;
   assign out_valid = (cnt_q != '0);
   assign out_data  = mem_q[rd_q];

   // ----------------------------------------
   // Next state
   // ----------------------------------------
   always_comb begin
      mem_d = mem_q;
      wr_d  = wr_q;
      rd_d  = rd_q;
      cnt_d = cnt_q;
      if (push) begin
         mem_d[wr_q] = in_data;
         wr_d        = (wr_q == PTR_LAST) ? '0 : wr_q + 1'b1;
      end
      if (pop) begin
         rd_d = (rd_q == PTR_LAST) ? '0 : rd_q + 1'b1;
      end
      if (push && !pop) begin
         cnt_d = cnt_q + 1'b1;
      end else if (pop && !push) begin
         cnt_d = cnt_q - 1'b1;
      end
      // Ready stays low while full, so a stalled drain really fills the buffer
      rdy_d = (cnt_d != CNT_FULL);
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         for (int i = 0; i < DEPTH; i++) begin
            mem_q[i] <= '0;
         end
         wr_q  <= '0;
         rd_q  <= '0;
         cnt_q <= '0;
         rdy_q <= 1'b0;
      end else begin
         mem_q <= mem_d;
         wr_q  <= wr_d;
         rd_q  <= rd_d;
         cnt_q <= cnt_d;
         rdy_q <= rdy_d;
      end
   end

endmodule

// [hdl/rxpop_top.sv]
// Receive payload output port: serial or nibble-parallel hand-off of DS3 payload.
// Assumes the upstream framer delivers one entry per line bit on clk, marking
// the first bit of each frame and each overhead bit; line clock and mode pin are asynchronous.
//
// Operation
// - Mode pin low selects serial output, high selects nibble output, and only that mode's data moves.
// - In serial mode the output clock follows the line clock continuously.
// - In serial mode each bit goes out on the serial pin at the output clock rising edge.
// - In serial mode the frame marker is high for the one bit period of a frame's first bit.
// - In serial mode the overhead flag is high in every bit period carrying an overhead bit.
// - In nibble mode payload leaves four bits at a time, changing on the output clock falling edge.
// - In nibble mode the output clock pulses once per nibble, 1176 times per frame.
// - In nibble mode the output clock is high for about a quarter of each nibble period.
// - In nibble mode the frame marker is high for the one nibble period of a frame's first nibble.
// - In nibble mode overhead bits are never sent and the overhead flag stays low.
`timescale 1ns/10ps
module rxpop_top (
   // Clock and reset
   input  wire logic                     clk,
   input  wire logic                     rst_n,
   // Line side pins
   input  wire logic                     line_clock,
   input  wire logic                     parallel_mode_select,
   // Upstream entries from the framer
   input  wire logic                     in_valid,
   input  wire logic                     in_bit,
   input  wire logic                     in_first,
   input  wire logic                     in_oh,
   output logic                          in_ready,
   // Terminal equipment side
   output logic                          rx_payload_out_clock,
   output logic                          rx_serial_payload_out,
   output logic [rxpop_pkg::NIB_W-1:0]   rx_four_bit_payload_out,
   output logic                          rx_frame_start_marker,
   output logic                          rx_overhead_bit_flag
);
   localparam logic [2:0] ASM_FULL = 3'(rxpop_pkg::NIB_W);

   // ----------------------------------------
   // Synchronisers and edge detect
   // ----------------------------------------
   logic line_s1_q, line_s2_q, line_s3_q;
   logic mode_s1_q, mode_s2_q;
   logic line_rise, line_fall;
   rxpop_pkg::rxpop_mode_t mode;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         line_s1_q <= 1'b0;
         line_s2_q <= 1'b0;
         line_s3_q <= 1'b0;
         mode_s1_q <= 1'b0;
         mode_s2_q <= 1'b0;
      end else begin
         line_s1_q <= line_clock;
         line_s2_q <= line_s1_q;
         line_s3_q <= line_s2_q;
         mode_s1_q <= parallel_mode_select;
         mode_s2_q <= mode_s1_q;
      end
   end

   assign line_rise = line_s2_q && !line_s3_q;
   assign line_fall = !line_s2_q && line_s3_q;
   assign mode      = rxpop_pkg::rxpop_mode_t'(mode_s2_q);

   // ----------------------------------------
   // Entry buffer
   // ----------------------------------------
   logic                          b_valid, b_pop;
   logic [rxpop_pkg::ENTRY_W-1:0] b_data;
   logic                          b_bit, b_first, b_oh;

   rxpop_fifo #(
      .WIDTH (rxpop_pkg::ENTRY_W),
      .DEPTH (rxpop_pkg::BUF_DEPTH)
   ) u_buf (
      .clk       (clk),
      .rst_n     (rst_n),
      .in_valid  (in_valid),
      .in_data   ({in_oh, in_first, in_bit}),
      .in_ready  (in_ready),
      .out_valid (b_valid),
      .out_data  (b_data),
      .out_ready (b_pop)
   );

   assign b_bit   = b_data[rxpop_pkg::ENT_BIT];
   assign b_first = b_data[rxpop_pkg::ENT_FIRST];
   assign b_oh    = b_data[rxpop_pkg::ENT_OH];

   // ----------------------------------------
   // Nibble assembly and output
   // ----------------------------------------
   logic [rxpop_pkg::NIB_W-1:0] asm_q, asm_d;
   logic [2:0]                  cnt_q, cnt_d;
   logic                        seen_q, seen_d;
   logic                        afirst_q, afirst_d;
   logic                        armed_q, armed_d;
   rxpop_pkg::rxpop_phase_t     ph_q, ph_d;

   logic                        clk_q, clk_d;
   logic                        ser_q, ser_d;
   logic [rxpop_pkg::NIB_W-1:0] nib_q, nib_d;
   logic                        frm_q, frm_d;
   logic                        oh_q, oh_d;

   always_comb begin
      asm_d    = asm_q;
      cnt_d    = cnt_q;
      seen_d   = seen_q;
      afirst_d = afirst_q;
      armed_d  = armed_q;
      ph_d     = ph_q;
      clk_d    = clk_q;
      ser_d    = ser_q;
      nib_d    = nib_q;
      frm_d    = frm_q;
      oh_d     = oh_q;
      b_pop    = 1'b0;
      unique case (mode)
         rxpop_pkg::MODE_SERIAL: begin
            asm_d   = '0;
            cnt_d   = '0;
            seen_d  = 1'b0;
            armed_d = 1'b0;
            ph_d    = rxpop_pkg::PH_LOW3;
            nib_d   = '0;
            if (line_rise) begin
               clk_d = 1'b1;
               b_pop = b_valid;
               // An empty buffer sends a zero bit with both markers low
               ser_d = b_valid && b_bit;
               frm_d = b_valid && b_first;
               oh_d  = b_valid && b_oh;
            end else if (line_fall) begin
               clk_d = 1'b0;
            end
         end
         rxpop_pkg::MODE_NIBBLE: begin
            ser_d = 1'b0;
            oh_d  = 1'b0;
            // Assembler drains faster than line rate, so nibbles are ready in time
            if (cnt_q != ASM_FULL && b_valid) begin
               b_pop  = 1'b1;
               seen_d = seen_q || b_first;
               if (!b_oh) begin
                  asm_d = {asm_q[rxpop_pkg::NIB_W-2:0], b_bit};
                  cnt_d = cnt_q + 3'h1;
                  if (cnt_q == '0) begin
                     afirst_d = seen_q || b_first;
                     seen_d   = 1'b0;
                  end
               end
            end
            if (line_rise) begin
               ph_d = rxpop_pkg::rxpop_phase_t'(ph_q + 2'h1);
               unique case (ph_q)
                  rxpop_pkg::PH_LOW3: begin
                     clk_d = armed_q;
                  end
                  rxpop_pkg::PH_HIGH: begin
                     clk_d = 1'b0;
                     // Data moves on the nibble clock falling edge
                     if (cnt_q == ASM_FULL) begin
                        nib_d   = asm_q;
                        frm_d   = afirst_q;
                        armed_d = 1'b1;
                        cnt_d   = '0;
                     end else begin
                        frm_d   = 1'b0;
                        armed_d = 1'b0;
                     end
                  end
                  rxpop_pkg::PH_LOW1, rxpop_pkg::PH_LOW2: begin
                     clk_d = 1'b0;
                  end
               endcase
            end
         end
      endcase
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         asm_q    <= '0;
         cnt_q    <= '0;
         seen_q   <= 1'b0;
         afirst_q <= 1'b0;
         armed_q  <= 1'b0;
         ph_q     <= rxpop_pkg::PH_LOW3;
         clk_q    <= 1'b0;
         ser_q    <= 1'b0;
         nib_q    <= '0;
         frm_q    <= 1'b0;
         oh_q     <= 1'b0;
      end else begin
         asm_q    <= asm_d;
         cnt_q    <= cnt_d;
         seen_q   <= seen_d;
         afirst_q <= afirst_d;
         armed_q  <= armed_d;
         ph_q     <= ph_d;
         clk_q    <= clk_d;
         ser_q    <= ser_d;
         nib_q    <= nib_d;
         frm_q    <= frm_d;
         oh_q     <= oh_d;
      end
   end

   assign rx_payload_out_clock    = clk_q;
   assign rx_serial_payload_out   = ser_q;
   assign rx_four_bit_payload_out = nib_q;
   assign rx_frame_start_marker   = frm_q;
   assign rx_overhead_bit_flag    = oh_q;

endmodule

// [dv/rxpop_chk.sv]
// Pin assertions for the receive payload output port.
// Assumes it is bound to rxpop_top and that clk runs at about 12.5x the line clock.
`timescale 1ns/10ps
module rxpop_chk (
   // Clock and reset
   input wire logic                        clk,
   input wire logic                        rst_n,
   // Line side
   input wire logic                        line_clock,
   input wire logic                        parallel_mode_select,
   // Terminal side
   input wire logic                        rx_payload_out_clock,
   input wire logic                        rx_serial_payload_out,
   input wire logic [rxpop_pkg::NIB_W-1:0] rx_four_bit_payload_out,
   input wire logic                        rx_frame_start_marker,
   input wire logic                        rx_overhead_bit_flag
);
   // ----
   // Helpers
   // ----
   // Checks wait 31 cycles after a mode change: the pin is synchronised late
   logic [4:0] md_q;
   logic       mp_q;
   logic [5:0] mk_q;
   logic [4:0] hi_q;
   logic       ser;
   logic       nib;
   assign ser = (md_q == 5'h1f) && !parallel_mode_select;
   assign nib = (md_q == 5'h1f) && parallel_mode_select;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         md_q <= 5'h00;
         mp_q <= 1'b0;
         mk_q <= 6'h00;
         hi_q <= 5'h00;
      end else begin
         mp_q <= parallel_mode_select;
         md_q <= (mp_q != parallel_mode_select) ? 5'h00 : md_q + 5'(md_q != 5'h1f);
         mk_q <= rx_frame_start_marker ? mk_q + 6'(mk_q != 6'h3f) : 6'h00;
         hi_q <= rx_payload_out_clock ? hi_q + 5'(hi_q != 5'h1f) : 5'h00;
      end
   end
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   // ----
   // Assertions
   // ----
   nib_quiet_a: assert property (nib |-> !rx_overhead_bit_flag && !rx_serial_payload_out)
      else $error("overhead flag or serial data active in nibble mode");
   ser_quiet_a: assert property (ser |-> rx_four_bit_payload_out == 4'h0)
      else $error("nibble data active in serial mode");
   clk_follow_a: assert property (ser && $rose(line_clock) |-> ##[1:5] $rose(rx_payload_out_clock))
      else $error("output clock missed a line clock rise");
   clk_fall_a: assert property (ser && $fell(line_clock) |-> ##[1:5] $fell(rx_payload_out_clock))
      else $error("output clock missed a line clock fall");
   ser_hold_a: assert property (ser && !$rose(rx_payload_out_clock) |->
      $stable({rx_serial_payload_out, rx_frame_start_marker, rx_overhead_bit_flag}))
      else $error("serial outputs changed away from a clock rise");
   ser_mark_a: assert property (ser && rx_frame_start_marker |-> mk_q <= 6'h0d)
      else $error("serial frame marker longer than one bit");
   nib_mark_a: assert property (nib && rx_frame_start_marker |-> mk_q <= 6'h33)
      else $error("nibble frame marker longer than one nibble");
   nib_edge_a: assert property (nib && ($changed(rx_four_bit_payload_out)
      || $changed(rx_frame_start_marker)) |-> !rx_payload_out_clock)
      else $error("nibble data changed while output clock high");
   nib_duty_a: assert property (nib && $fell(rx_payload_out_clock) |->
      hi_q inside {[5'h0b:5'h0e]})
      else $error("nibble clock high time not one line period");
endmodule

bind rxpop_top rxpop_chk u_chk (
   .clk                     (clk),
   .rst_n                   (rst_n),
   .line_clock              (line_clock),
   .parallel_mode_select    (parallel_mode_select),
   .rx_payload_out_clock    (rx_payload_out_clock),
   .rx_serial_payload_out   (rx_serial_payload_out),
   .rx_four_bit_payload_out (rx_four_bit_payload_out),
   .rx_frame_start_marker   (rx_frame_start_marker),
   .rx_overhead_bit_flag    (rx_overhead_bit_flag)
);

// [dv/rxpop_term.sv]
// Terminal equipment model: captures the port on each output clock rise.
// Assumes the port pins are registered on clk, so a rise is seen by sampling.
`timescale 1ns/10ps
module rxpop_term (
   // Clock and reset
   input wire logic       clk,
   input wire logic       rst_n,
   // Port pins
   input wire logic       mode,
   input wire logic       pclk,
   input wire logic       ser,
   input wire logic [3:0] nib,
   input wire logic       frm,
   input wire logic       ohf
);
   logic bits[$];
   int   mk_pos[$];
   int   cnt;
   int   frame_pulses;
   logic started;
   logic pclk_q;
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pclk_q = 1'b0;
         started = 1'b0;
         cnt = 0;
         frame_pulses = 0;
      end else begin
         if (pclk && !pclk_q) begin
            if (frm) begin
               started = 1'b1;
               mk_pos.push_back(bits.size());
               frame_pulses = cnt;
               cnt = 0;
            end
            cnt++;
            if (started && !mode && !ohf) bits.push_back(ser);
            if (started && mode) for (int i = 3; i >= 0; i--) bits.push_back(nib[i]);
         end
         pclk_q = pclk;
      end
   end
endmodule

// [dv/tb_rx_payload_output_port.sv]
// Self-checking bench for the receive payload output port.
// Assumes the terminal model and the bound checker.
`timescale 1ns/10ps
module tb_rx_payload_output_port;
   logic                        clk, rst_n, line_clock, parallel_mode_select;
   logic                        in_valid, in_bit, in_first, in_oh, in_ready;
   logic                        rx_payload_out_clock, rx_serial_payload_out;
   logic                        rx_frame_start_marker, rx_overhead_bit_flag;
   logic [rxpop_pkg::NIB_W-1:0] rx_four_bit_payload_out;
   logic [15:0]                 lf;
   logic                        exp[$];
   int                          miscompares, checks;

   rxpop_top u_dut (.clk(clk), .rst_n(rst_n), .line_clock(line_clock),
      .parallel_mode_select(parallel_mode_select), .in_valid(in_valid), .in_bit(in_bit),
      .in_first(in_first), .in_oh(in_oh), .in_ready(in_ready),
      .rx_payload_out_clock(rx_payload_out_clock), .rx_serial_payload_out(rx_serial_payload_out),
      .rx_four_bit_payload_out(rx_four_bit_payload_out),
      .rx_frame_start_marker(rx_frame_start_marker), .rx_overhead_bit_flag(rx_overhead_bit_flag));
   rxpop_term u_term (.clk(clk), .rst_n(rst_n), .mode(parallel_mode_select),
      .pclk(rx_payload_out_clock), .ser(rx_serial_payload_out), .nib(rx_four_bit_payload_out),
      .frm(rx_frame_start_marker), .ohf(rx_overhead_bit_flag));

   // ----
   // Clocks
   // ----
   initial clk = 1'b0;
   always #5 clk = ~clk;
   // Offset keeps line edges away from clk edges
   initial begin
      line_clock = 1'b0;
      #1;
      forever #62.5 line_clock = ~line_clock;
   end

   // ----
   // Helpers
   // ----
   function automatic logic [15:0] nxt(input logic [15:0] v);
      return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
   endfunction
   task chk(input logic [15:0] got, input logic [15:0] want, input string what);
      checks++;
      if (got !== want) begin
         miscompares++;
         $display("wrong value at %0t: %s", $time, what);
      end
   endtask
   task close_out();
      $display("%0d checks, %0d miscompares", checks, miscompares);
      if (miscompares == 0 && checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   // Frame start on entry 0, an overhead bit every 85 entries; refusals are held
   task feed(input int n, input int flen);
      int i, k;
      for (i = 0; i < n; i++) begin
         lf = nxt(lf);
         in_valid <= 1'b1;
         in_bit <= lf[0];
         in_first <= (i % flen) == 0;
         in_oh <= (i % flen) % 85 == 0;
         if ((i % flen) % 85 != 0) exp.push_back(lf[0]);
         k = 0;
         do begin
            @(posedge clk);
            k++;
         end while (in_ready !== 1'b1 && k < 5000);
         chk(16'(in_ready), 16'h0001, "entry refused too long");
      end
      in_valid <= 1'b0;
   endtask
   task run(input logic md, input int n, input int flen, input int m2);
      int j;
      parallel_mode_select <= md;
      repeat (40) @(posedge clk);
      @(negedge clk);
      u_term.started = 1'b0;
      u_term.bits.delete();
      u_term.mk_pos.delete();
      exp.delete();
      @(posedge clk);
      feed(n, flen);
      repeat (400) @(posedge clk);
      chk(16'(u_term.bits.size() >= exp.size()), 16'h0001, "captured count");
      for (j = 0; j < exp.size() && j < u_term.bits.size(); j++)
         chk(16'(u_term.bits[j]), 16'(exp[j]), "payload bit");
      chk(16'(u_term.mk_pos[1]), 16'(m2), "frame marker position");
      chk(16'(u_term.mk_pos.size()), 16'h0002, "frame marker count");
      chk(16'(u_term.mk_pos[0]), 16'h0000, "first frame marker position");
      // Serial mode with an empty buffer still clocks out zero bits
      for (j = exp.size(); md == 1'b0 && j < u_term.bits.size(); j++)
         chk(16'(u_term.bits[j]), 16'h0000, "idle bit");
      $display("test mode %0d done", md);
   endtask

   // ----
   // Main sequence
   // ----
   initial begin
      rst_n = 1'b0;
      parallel_mode_select = 1'b0;
      in_valid = 1'b0;
      in_bit = 1'b0;
      in_first = 1'b0;
      in_oh = 1'b0;
      lf = 16'h0017;
      miscompares = 0;
      checks = 0;
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      run(1'b0, 300, 170, 168);
      run(1'b1, 4769, 4760, 4704);
      chk(16'(u_term.frame_pulses), 16'(rxpop_pkg::FRAME_NIBBLES), "pulses per frame");
      close_out();
   end
   initial begin
      #900000;
      miscompares++;
      close_out();
   end
endmodule
